/* File: rtl/escape_decode_pkg.sv */
// Shared constants, encodings and carrier types for the bit-field and escape decoder.
package escape_decode_pkg;

  // ----------------------------------------------------------------
  // Opcode encodings
  // ----------------------------------------------------------------
  localparam logic [6:0] UNSIGNED_DIVIDE_OP_HI = 7'b1111011;
  localparam logic [2:0] UNSIGNED_DIVIDE_OP_SUB = 3'b110;
  localparam logic [2:0] PFX_HI = 3'b001;
  localparam logic [2:0] PFX_LO = 3'b110;
  localparam logic [7:0] EXT_ESC = 8'h0F;
  localparam logic [7:0] EXT_REG = 8'h33;
  localparam logic [7:0] EXT_IMM = 8'h3B;
  localparam logic [4:0] ESC_A_HI = 5'b11011;
  localparam logic [6:0] ESC_B_HI = 7'b0110011;

  // ----------------------------------------------------------------
  // Mode field, segments and register indices
  // ----------------------------------------------------------------
  localparam logic [1:0] MOD_NODISP = 2'b00;
  localparam logic [1:0] MOD_D8 = 2'b01;
  localparam logic [1:0] MOD_D16 = 2'b10;
  localparam logic [1:0] MOD_REG = 2'b11;
  localparam logic [2:0] MEM_DIRECT = 3'b110;
  localparam logic [1:0] SEG_DS1 = 2'b00;
  localparam logic [1:0] SEG_PS = 2'b01;
  localparam logic [1:0] SEG_SS = 2'b10;
  localparam logic [1:0] SEG_DS0 = 2'b11;
  localparam logic [2:0] REG_AW = 3'h0;
  localparam logic [2:0] REG_DW = 3'h2;
  localparam logic [2:0] REG_IX = 3'h6;

  // ----------------------------------------------------------------
  // Lengths, sizes and arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [1:0] SIZE_BYTE = 2'b00;
  localparam logic [1:0] SIZE_WORD = 2'b01;
  localparam logic [1:0] SIZE_DWORD = 2'b10;
  localparam logic [4:0] OFF_LIMIT = 5'h0F;
  localparam logic [15:0] IX_STEP = 16'h0002;
  localparam logic [3:0] LEN_MAX = 4'hF;
  localparam logic [4:0] DIV_STEPS = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01,
    ST_DIV = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_DIV = 2'b01,
    OP_EXT = 2'b10,
    OP_ESC = 2'b11
  } op_t;

  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } instr_t;

  typedef struct packed {
    logic acc_wr;
    logic [15:0] acc_val;
    logic dw_wr;
    logic [15:0] dw_val;
    logic ix_wr;
    logic [15:0] ix_val;
    logic byte_wr;
    logic [2:0] byte_idx;
    logic [7:0] byte_val;
  } wb_t;

  typedef struct packed {
    logic [19:0] phys;
    logic [15:0] ea;
    logic [1:0] seg;
    logic [1:0] size;
    logic capture;
  } memreq_t;

  typedef struct packed {
    logic irq_ok;
    logic nmi_ok;
    logic step_ok;
  } gate_t;

endpackage

/* File: rtl/udiv_unit.sv */
// Iterative unsigned divider with quotient overflow detection.
`timescale 1ns/1ns
module udiv_unit (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Request
  input wire logic start_i,
  input wire logic byte_mode_i,
  input wire logic [31:0] dividend_i,
  input wire logic [15:0] divisor_i,
  // Result
  output logic done_o,
  output logic ovf_o,
  output logic [15:0] quot_o,
  output logic [15:0] rem_o
);
  import escape_decode_pkg::*;

  logic busy_q;
  logic [4:0] cnt_q;
  logic [15:0] rem_q;
  logic [15:0] quo_q;
  logic [31:0] dvd_q;
  logic [15:0] dvs_q;
  logic [16:0] trial;
  logic take;
  logic ovf_d;

  // A quotient that cannot fit, zero divisor included, is caught before iterating.
  assign ovf_d = byte_mode_i ? (dividend_i[15:8] >= divisor_i[7:0])
                             : (dividend_i[31:16] >= divisor_i);
  assign trial = {rem_q, quo_q[15]};
  assign take = trial >= {1'b0, dvs_q};
  assign quot_o = quo_q;
  assign rem_o = rem_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
      rem_q <= 16'h0000;
      quo_q <= 16'h0000;
      dvd_q <= 32'h0000_0000;
      dvs_q <= 16'h0000;
      done_o <= 1'b0;
      ovf_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        dvd_q <= dividend_i;
        dvs_q <= divisor_i;
        rem_q <= byte_mode_i ? 16'h0000 : dividend_i[31:16];
        quo_q <= dividend_i[15:0];
        cnt_q <= 5'h00;
        ovf_o <= ovf_d;
        busy_q <= !ovf_d;
        done_o <= ovf_d;
      end else if (busy_q) begin
        rem_q <= take ? 16'(trial - {1'b0, dvs_q}) : trial[15:0];
        quo_q <= {quo_q[14:0], take};
        cnt_q <= 5'(cnt_q + 5'h01);
        if (cnt_q == 5'(DIV_STEPS - 5'h01)) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  div_identity_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    done_o && !ovf_o |-> ({16'h0000, rem_q} + 32'(quo_q) * 32'(dvs_q) == dvd_q)
                         && (rem_q < dvs_q))
    else $error("divider result does not satisfy dividend identity");

endmodule

/* File: rtl/bitfield_escape_decode.sv */
// Decode and execute unit for divide, prefixes, interrupt enable, bit-field extract and escapes.
// Behaviour
// - Recognise unsigned divide, width bit picks byte or word; two to four bytes.
// - Byte: accumulator split into quotient low, remainder high; word uses pair.
// - Quotient overflow or zero divisor raises vector 0, no result written.
// - Segment prefix selects the segment of the next instruction's memory operand.
// - No hardware interrupt or single-step between prefix and next instruction.
// - Interrupt-enable instruction sets the maskable enable flag, no arithmetic flags.
// - Maskable interrupts stay blocked until one further instruction has executed.
// - Extract reads field at index pointer plus offset, zero-fills the accumulator.
// - Length operand from register or immediate encodes length minus one.
// - Offset advances by length plus one; past 15 it wraps, pointer advances.
// - Fields crossing byte boundaries are assembled from adjacent bytes.
// - Extract source defaults to the first data segment, prefix may override.
// - Register-form escape does nothing inside the processor.
// - Memory-form escape computes the address and starts a memory read.
// - Data read for an escape is never captured into processor registers.
// - First escape group: upper five bits 11011, then a mode byte.
// - Second escape group behaves the same as the first.
// - Second escape group: first byte 0110011 plus one variable bit.
`timescale 1ns/1ns
module bitfield_escape_decode #(
  parameter logic [7:0] EI_OPCODE = 8'hFB
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Instruction stream
  input wire logic instr_valid_i,
  input wire escape_decode_pkg::instr_t instr_i,
  output logic instr_ready_o,
  // Register file view
  input wire logic [7:0][15:0] word_regs_i,
  input wire logic [7:0][7:0] byte_regs_i,
  input wire logic [3:0][15:0] seg_base_i,
  input wire logic [15:0] ea_base_i,
  // Memory read port
  output logic mem_req_o,
  output escape_decode_pkg::memreq_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Results
  output logic done_o,
  output logic [2:0] instr_len_o,
  output escape_decode_pkg::wb_t wb_o,
  output logic div_fault_o,
  // Interrupt acceptance
  output logic irq_enable_o,
  output escape_decode_pkg::gate_t gate_o
);
  import escape_decode_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_q;
  op_t op_q;
  logic byte_mode_q;
  logic [15:0] aw_q;
  logic [15:0] dw_q;
  logic [15:0] ix_q;
  logic [3:0] off_q;
  logic [3:0] len_q;
  logic [2:0] off_idx_q;
  logic ovr_valid_q;
  logic [1:0] ovr_seg_q;
  logic ei_shadow_q;
  logic done_pfx_q;
  logic done_ei_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic accept;
  logic is_pfx;
  logic is_ei;
  logic is_unsigned_divide_op;
  logic is_ext;
  logic is_esc;
  logic reg_form;
  logic needs_mem;
  logic [1:0] mod_f;
  logic [2:0] rm_f;
  logic [2:0] rm_len;
  logic [15:0] disp;
  logic [15:0] ea;
  logic [1:0] seg_sel;

  assign instr_ready_o = (state_q == ST_IDLE);
  assign accept = instr_valid_i && instr_ready_o;
  assign is_pfx = instr_i.b0[7:5] == PFX_HI && instr_i.b0[2:0] == PFX_LO;
  assign is_ei = instr_i.b0 == EI_OPCODE;
  assign is_unsigned_divide_op = instr_i.b0[7:1] == UNSIGNED_DIVIDE_OP_HI && instr_i.b1[5:3] == UNSIGNED_DIVIDE_OP_SUB;
  assign is_ext = instr_i.b0 == EXT_ESC && (instr_i.b1 == EXT_REG || instr_i.b1 == EXT_IMM);
  assign is_esc = instr_i.b0[7:3] == ESC_A_HI || instr_i.b0[7:1] == ESC_B_HI;
  assign mod_f = instr_i.b1[7:6];
  assign rm_f = instr_i.b1[2:0];
  assign reg_form = mod_f == MOD_REG;
  assign needs_mem = is_ext || ((is_unsigned_divide_op || is_esc) && !reg_form);

  always_comb begin
    disp = 16'h0000;
    rm_len = LEN_2;
    if (mod_f == MOD_D8) begin
      disp = {{8{instr_i.b2[7]}}, instr_i.b2};
      rm_len = LEN_3;
    end else if (mod_f == MOD_D16 || (mod_f == MOD_NODISP && rm_f == MEM_DIRECT)) begin
      disp = {instr_i.b3, instr_i.b2};
      rm_len = LEN_4;
    end
  end

  // Memory operands take the prefix segment when one is pending, else the first data segment.
  assign seg_sel = ovr_valid_q ? ovr_seg_q : SEG_DS0;
  always_comb begin
    if (is_ext) begin
      ea = word_regs_i[REG_IX];
    end else if (mod_f == MOD_NODISP && rm_f == MEM_DIRECT) begin
      ea = disp;
    end else begin
      ea = 16'(ea_base_i + disp);
    end
  end

  // ----------------------------------------------------------------
  // Divider hookup
  // ----------------------------------------------------------------
  logic div_start;
  logic div_byte;
  logic [31:0] div_dividend;
  logic [15:0] div_divisor;
  logic div_done;
  logic div_ovf;
  logic [15:0] div_quot;
  logic [15:0] div_rem;
  logic mem_done;

  assign mem_done = state_q == ST_MEM && mem_ack_i;
  assign div_start = (accept && is_unsigned_divide_op && reg_form) || (mem_done && op_q == OP_DIV);
  assign div_byte = accept ? !instr_i.b0[0] : byte_mode_q;

  always_comb begin
    if (accept) begin
      div_dividend = {div_byte ? 16'h0000 : word_regs_i[REG_DW], word_regs_i[REG_AW]};
      div_divisor = div_byte ? {8'h00, byte_regs_i[rm_f]} : word_regs_i[rm_f];
    end else begin
      div_dividend = {div_byte ? 16'h0000 : dw_q, aw_q};
      div_divisor = div_byte ? {8'h00, mem_rdata_i[7:0]} : mem_rdata_i[15:0];
    end
  end

  udiv_unit u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(div_start),
    .byte_mode_i(div_byte),
    .dividend_i(div_dividend),
    .divisor_i(div_divisor),
    .done_o(div_done),
    .ovf_o(div_ovf),
    .quot_o(div_quot),
    .rem_o(div_rem)
  );

  // ----------------------------------------------------------------
  // Sequencer and memory request
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      mem_req_o <= 1'b0;
      mem_o <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            op_q <= is_unsigned_divide_op ? OP_DIV : is_ext ? OP_EXT : is_esc ? OP_ESC : OP_NONE;
            if (needs_mem) begin
              state_q <= ST_MEM;
              mem_req_o <= 1'b1;
              mem_o.ea <= ea;
              mem_o.seg <= seg_sel;
              mem_o.phys <= 20'({seg_base_i[seg_sel], 4'h0} + {4'h0, ea});
              mem_o.size <= is_ext ? SIZE_DWORD : (is_unsigned_divide_op && !instr_i.b0[0]) ? SIZE_BYTE
                                   : SIZE_WORD;
              mem_o.capture <= !is_esc;
            end else if (is_unsigned_divide_op) begin
              state_q <= ST_DIV;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            state_q <= (op_q == OP_DIV) ? ST_DIV : ST_IDLE;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operand capture at acceptance
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      byte_mode_q <= 1'b0;
      aw_q <= 16'h0000;
      dw_q <= 16'h0000;
      ix_q <= 16'h0000;
      off_q <= 4'h0;
      len_q <= 4'h0;
      off_idx_q <= 3'h0;
    end else if (accept) begin
      byte_mode_q <= !instr_i.b0[0];
      aw_q <= word_regs_i[REG_AW];
      dw_q <= word_regs_i[REG_DW];
      ix_q <= word_regs_i[REG_IX];
      off_idx_q <= instr_i.b2[2:0];
      off_q <= byte_regs_i[instr_i.b2[2:0]][3:0];
      len_q <= (instr_i.b1 == EXT_REG) ? byte_regs_i[instr_i.b2[5:3]][3:0]
                                       : instr_i.b3[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Bit-field extraction datapath
  // ----------------------------------------------------------------
  logic [31:0] ext_shift;
  logic [15:0] ext_mask;
  logic [4:0] off_sum;
  logic ext_wrap;

  assign ext_shift = mem_rdata_i >> off_q;
  assign ext_mask = 16'hFFFF >> (LEN_MAX - len_q);
  assign off_sum = 5'({1'b0, off_q} + {1'b0, len_q} + 5'h01);
  assign ext_wrap = off_sum > OFF_LIMIT;

  // ----------------------------------------------------------------
  // Completion and write-back
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      div_fault_o <= 1'b0;
      instr_len_o <= 3'h0;
      wb_o <= '0;
      done_pfx_q <= 1'b0;
      done_ei_q <= 1'b0;
    end else begin
      done_o <= 1'b0;
      div_fault_o <= 1'b0;
      done_pfx_q <= 1'b0;
      done_ei_q <= 1'b0;
      wb_o.acc_wr <= 1'b0;
      wb_o.dw_wr <= 1'b0;
      wb_o.ix_wr <= 1'b0;
      wb_o.byte_wr <= 1'b0;
      if (accept) begin
        instr_len_o <= (is_pfx || is_ei) ? LEN_1 : is_ext ? (instr_i.b1 == EXT_REG ? LEN_3
                       : LEN_4) : (is_unsigned_divide_op || is_esc) ? rm_len : LEN_1;
        // Register-form escapes and one-byte controls finish without touching state.
        if (!needs_mem && !is_unsigned_divide_op) begin
          done_o <= 1'b1;
          done_pfx_q <= is_pfx;
          done_ei_q <= is_ei;
        end
      end
      if (mem_done && op_q == OP_EXT) begin
        done_o <= 1'b1;
        wb_o.acc_wr <= 1'b1;
        wb_o.acc_val <= ext_shift[15:0] & ext_mask;
        wb_o.byte_wr <= 1'b1;
        wb_o.byte_idx <= off_idx_q;
        wb_o.byte_val <= {4'h0, off_sum[3:0]};
        wb_o.ix_wr <= ext_wrap;
        wb_o.ix_val <= 16'(ix_q + IX_STEP);
      end
      if (mem_done && op_q == OP_ESC) begin
        done_o <= 1'b1;
      end
      if (state_q == ST_DIV && div_done) begin
        done_o <= 1'b1;
        if (div_ovf) begin
          div_fault_o <= 1'b1;
        end else if (byte_mode_q) begin
          wb_o.acc_wr <= 1'b1;
          wb_o.acc_val <= {div_rem[7:0], div_quot[7:0]};
        end else begin
          wb_o.acc_wr <= 1'b1;
          wb_o.acc_val <= div_quot;
          wb_o.dw_wr <= 1'b1;
          wb_o.dw_val <= div_rem;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Prefix window and interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ovr_valid_q <= 1'b0;
      ovr_seg_q <= SEG_DS0;
      ei_shadow_q <= 1'b0;
      irq_enable_o <= 1'b0;
    end else begin
      if (accept && is_pfx) begin
        ovr_valid_q <= 1'b1;
        ovr_seg_q <= instr_i.b0[4:3];
      end else if (done_o && !done_pfx_q) begin
        ovr_valid_q <= 1'b0;
      end
      if (accept && is_ei) begin
        irq_enable_o <= 1'b1;
        ei_shadow_q <= 1'b1;
      end else if (done_o && !done_ei_q) begin
        ei_shadow_q <= 1'b0;
      end
    end
  end

  assign gate_o.irq_ok = irq_enable_o && !ei_shadow_q && !ovr_valid_q;
  assign gate_o.nmi_ok = !ovr_valid_q;
  assign gate_o.step_ok = !ovr_valid_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  div_fault_nowrite_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == ST_DIV && div_done && div_ovf |=> div_fault_o && done_o && !wb_o.acc_wr
                                                && !wb_o.dw_wr)
    else $error("divide overflow did not fault cleanly");

  prefix_blocks_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    accept && is_pfx |=> !gate_o.irq_ok && !gate_o.nmi_ok && !gate_o.step_ok)
    else $error("interrupt accepted right after a segment prefix");

  ei_sets_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    accept && is_ei |=> irq_enable_o && done_o && !wb_o.acc_wr)
    else $error("interrupt enable instruction did not set the flag");

  ei_shadow_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    accept && is_ei |=> !gate_o.irq_ok ##1 !gate_o.irq_ok)
    else $error("maskable interrupt opened before next instruction");

  esc_reg_noop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    accept && is_esc && reg_form |=> done_o && !mem_req_o && !wb_o.acc_wr && !wb_o.byte_wr)
    else $error("register escape changed processor state");

  esc_no_capture_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mem_done && op_q == OP_ESC |-> !mem_o.capture ##1 (done_o && !wb_o.acc_wr && !wb_o.dw_wr))
    else $error("escape read data was captured");

  ext_zero_fill_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mem_done && op_q == OP_EXT |=> wb_o.acc_wr && (wb_o.acc_val & ~$past(ext_mask)) == 16'h0000)
    else $error("extract left upper accumulator bits set");

  ext_wrap_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wb_o.ix_wr |-> wb_o.ix_val == 16'(ix_q + IX_STEP) && wb_o.byte_val < 8'h10)
    else $error("index pointer not advanced by one word on wrap");

  prefix_segment_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    accept && needs_mem && ovr_valid_q |=> mem_req_o && mem_o.seg == $past(ovr_seg_q))
    else $error("memory operand ignored the segment prefix");

endmodule

/* File: verif/mem_model.sv */
// Behavioural memory and coprocessor bus partner for the decoder's read port.
`timescale 1ns/1ns
module mem_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Read port
  input wire logic mem_req_i,
  input wire logic [3:0] lat_i,
  input wire logic [31:0] data_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [3:0] cnt_q;
  logic busy_q;

  // Data is shown only with the acknowledge; otherwise the bus inverts its previous value every cycle.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0000_0000;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (!mem_req_i) begin
        cnt_q <= 4'h0;
        busy_q <= 1'b0;
      end else if (!busy_q && !mem_ack_o) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == lat_i) begin
          mem_ack_o <= 1'b1;
          mem_rdata_o <= data_i;
          busy_q <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench for the bit-field and escape decoder.
`timescale 1ns/1ns
module tb_top;
  import escape_decode_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid = 1'b0;
  instr_t instr = '0;
  logic [7:0][15:0] wr = '0;
  logic [7:0][7:0] br = '0;
  logic [3:0][15:0] sb = {16'h2000, 16'h3000, 16'h4000, 16'h5000};
  logic [15:0] ea_base = 16'h0040;
  logic mem_req_o, mem_ack, done_o, div_fault_o, irq_enable_o, instr_ready_o;
  logic [31:0] rdata;
  memreq_t mem_o, req_q;
  logic [2:0] instr_len_o, len_q;
  wb_t wb_o, wb_q;
  gate_t gate_o;
  logic fault_q, seen_q;
  logic [3:0] m_lat = 4'h1;
  logic [31:0] m_data = 32'h0;
  logic [15:0] fld;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  always #2 core_clk_i = ~core_clk_i;

  bitfield_escape_decode dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid), .instr_i(instr), .instr_ready_o(instr_ready_o),
    .word_regs_i(wr), .byte_regs_i(br), .seg_base_i(sb), .ea_base_i(ea_base),
    .mem_req_o(mem_req_o), .mem_o(mem_o), .mem_ack_i(mem_ack), .mem_rdata_i(rdata),
    .done_o(done_o), .instr_len_o(instr_len_o), .wb_o(wb_o), .div_fault_o(div_fault_o),
    .irq_enable_o(irq_enable_o), .gate_o(gate_o));

  mem_model mem_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req_o),
    .lat_i(m_lat), .data_i(m_data), .mem_ack_o(mem_ack), .mem_rdata_o(rdata));

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Presents one instruction, waits for its completion and keeps what came back.
  task automatic exec(input instr_t ins, input logic [3:0] lat, input logic [31:0] d);
    int n;
    n = 0;
    m_lat = lat;
    m_data = d;
    seen_q = 1'b0;
    @(negedge core_clk_i);
    instr_valid = 1'b1;
    instr = ins;
    @(negedge core_clk_i);
    instr_valid = 1'b0;
    while (done_o !== 1'b1 && n < 100) begin
      if (mem_req_o === 1'b1) begin
        seen_q = 1'b1;
        req_q = mem_o;
      end
      @(negedge core_clk_i);
      n++;
    end
    if (n == 100) chk(32'h0, 32'h1);
    wb_q = wb_o;
    fault_q = div_fault_o;
    len_q = instr_len_o;
  endtask

  task automatic t_divide();
    wr[0] = 16'h0005;
    br[3] = 8'h03;
    exec({8'h00, 8'h00, 8'hF3, 8'hF6}, 4'h0, 32'h0);
    chk(len_q, 3'h2);
    chk({wb_q.acc_wr, wb_q.acc_val, fault_q}, {1'b1, 16'h0201, 1'b0});
    br[4] = 8'h00;
    exec({8'h00, 8'h00, 8'hF4, 8'hF6}, 4'h0, 32'h0);
    chk({fault_q, wb_q.acc_wr}, {1'b1, 1'b0});
    wr[0] = 16'h0006;
    wr[1] = 16'h0007;
    wr[2] = 16'h0001;
    exec({8'h00, 8'h00, 8'hF1, 8'hF7}, 4'h0, 32'h0);
    chk({wb_q.acc_val, wb_q.dw_wr, wb_q.dw_val}, {16'h2493, 1'b1, 16'h0001});
    exec({8'h00, 8'h00, 8'h30, 8'hF6}, 4'h2, 32'h0000_0004);
    chk({req_q.size, len_q, wb_q.acc_val, fault_q}, {2'b00, 3'h2, 16'h0201, 1'b0});
  endtask

  task automatic t_irq_enable();
    exec({8'h00, 8'h00, 8'h00, 8'hFB}, 4'h0, 32'h0);
    chk({irq_enable_o, gate_o.irq_ok, wb_q.acc_wr}, 3'b100);
    exec({8'h00, 8'h00, 8'hC0, 8'h67}, 4'h0, 32'h0);
    chk({seen_q, wb_q.acc_wr, wb_q.dw_wr, len_q}, {3'b000, 3'h2});
    chk(gate_o.irq_ok, 1'b0);
    @(negedge core_clk_i);
    chk(gate_o.irq_ok, 1'b1);
  endtask

  task automatic t_extract();
    wr[6] = 16'h0100;
    br[1] = 8'h0E;
    br[2] = 8'h05;
    exec({8'h00, 8'h00, 8'h00, 8'h26}, 4'h0, 32'h0);
    chk({gate_o.nmi_ok, gate_o.step_ok}, 2'b00);
    fld = 16'(32'hA5C3_7E19 >> 14) & 16'h003F;
    exec({8'h00, 8'hD1, 8'h33, 8'h0F}, 4'h3, 32'hA5C3_7E19);
    chk({req_q.seg, req_q.ea, req_q.capture}, {2'b00, 16'h0100, 1'b1});
    chk(req_q.phys, {4'h0, sb[0]} * 20'h10 + 20'h00100);
    chk({len_q, wb_q.acc_val}, {3'h3, fld});
    chk({wb_q.byte_wr, wb_q.byte_idx, wb_q.byte_val}, {1'b1, 3'h1, 8'h04});
    chk({wb_q.ix_wr, wb_q.ix_val}, {1'b1, 16'h0102});
    @(negedge core_clk_i);
    chk(gate_o.nmi_ok, 1'b1);
    br[0] = 8'h00;
    wr[6] = 16'h0102;
    exec({8'h0F, 8'hC0, 8'h3B, 8'h0F}, 4'h0, 32'h1234_9ABC);
    chk({req_q.seg, len_q, wb_q.acc_val}, {2'b11, 3'h4, 16'h9ABC});
    chk({wb_q.byte_val, wb_q.ix_val}, {8'h00, 16'h0104});
  endtask

  task automatic t_escape();
    exec({8'h00, 8'h00, 8'h28, 8'hD9}, 4'h6, 32'hDEAD_BEEF);
    chk({seen_q, req_q.capture, req_q.size}, {2'b10, 2'b01});
    chk(req_q.phys, 20'h20040);
    chk({len_q, wb_q.acc_wr, wb_q.dw_wr, wb_q.ix_wr, wb_q.byte_wr}, {3'h2, 4'h0});
    exec({8'h00, 8'h00, 8'h28, 8'h66}, 4'h1, 32'h0F0F_0F0F);
    chk({seen_q, req_q.capture, wb_q.acc_wr}, 3'b100);
    exec({8'h00, 8'h00, 8'hE5, 8'hDE}, 4'h0, 32'h0);
    chk({seen_q, wb_q.acc_wr, len_q}, {2'b00, 3'h2});
  endtask

  initial begin
    repeat (10) @(negedge core_clk_i);
    chk({instr_ready_o, irq_enable_o, gate_o}, 5'b10011);
    rst_n_i = 1'b1;
    t_divide();
    t_irq_enable();
    t_extract();
    t_escape();
    final_report();
  end
endmodule
